//--- slc_pkg.sv
// Purpose: shared constants and types for the stack language core
// Assumes: 10 MHz system clock, 8-bit data everywhere
// Notes:   opcodes are the printable character codes of the language, except halt at 0xff
package slc_pkg;

  // ==========================================================
  // sizes
  localparam int PROG_DEPTH  = 32;
  localparam int STACK_DEPTH = 32;
  localparam int DATA_DEPTH  = 8;

  // ==========================================================
  // reset values
  localparam logic [7:0] PROG_RESET  = 8'hff;
  localparam logic [7:0] STACK_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET  = 8'h00;
  localparam logic [7:0] PC_RESET    = 8'h00;
  localparam logic [7:0] SP_RESET    = 8'h00;

  // ==========================================================
  // host access register select codes
  localparam logic [1:0] HREG_PROGRAM_COUNTER   = 2'h0;
  localparam logic [1:0] HREG_STACK_POINTER     = 2'h1;
  localparam logic [1:0] HREG_IMMEDIATE_OPCODE  = 2'h2;
  localparam logic [1:0] HREG_STACK_TOP_ACCESS  = 2'h3;

  // ==========================================================
  // data space map
  localparam logic [7:0] DADDR_RAM_LAST     = 8'h07;
  localparam logic [7:0] DADDR_IO_FIRST     = 8'h20;
  localparam logic [7:0] DADDR_IO_LAST      = 8'h5f;
  localparam logic [7:0] DADDR_PIN_TOGGLE   = 8'h36;
  localparam logic [7:0] DADDR_DIRECTION    = 8'h37;
  localparam logic [7:0] DADDR_OUTPUT_LEVEL = 8'h38;

  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_DELAY  = 8'h2c;
  localparam logic [7:0] OP_SHR    = 8'h3e;
  localparam logic [7:0] OP_SHL    = 8'h3c;
  localparam logic [7:0] OP_JUMP   = 8'h3d;
  localparam logic [7:0] OP_LOOP   = 8'h40;
  localparam logic [7:0] OP_AND    = 8'h26;
  localparam logic [7:0] OP_OR     = 8'h7c;
  localparam logic [7:0] OP_XOR    = 8'h5e;
  localparam logic [7:0] OP_ADD    = 8'h2b;
  localparam logic [7:0] OP_SUB    = 8'h2d;
  localparam logic [7:0] OP_DUP    = 8'h32;
  localparam logic [7:0] OP_PREAD  = 8'h3f;
  localparam logic [7:0] OP_PWRITE = 8'h21;
  localparam logic [7:0] OP_DREAD  = 8'h72;
  localparam logic [7:0] OP_DWRITE = 8'h77;
  localparam logic [7:0] OP_ROT    = 8'h78;
  localparam logic [7:0] OP_SLEEP  = 8'h7a;
  localparam logic [7:0] OP_HALT   = 8'hff;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int DELAY_UNIT_US   = 1000;
  localparam int DELAY_CYCLES    = (DELAY_UNIT_US * 1000) / CLK_PERIOD_NS;
  localparam int DELAY_CNT_W     = 16;

  // ==========================================================
  // core state
  typedef enum logic [2:0] {
    ST_HALT  = 3'b000,
    ST_RUN   = 3'b001,
    ST_DELAY = 3'b010,
    ST_SLEEP = 3'b011
  } slc_state_t;

  typedef struct packed {
    slc_state_t                          state;
    logic                                single;
    logic                                run_q;
    logic                                step_q;
    logic                                load_q;
    logic [7:0]                          pc;
    logic [7:0]                          sp;
    logic [7:0]                          sr;
    logic [7:0]                          ddr;
    logic [7:0]                          port;
    logic [7:0]                          ms;
    logic [DELAY_CNT_W-1:0]              cyc;
    logic [PROG_DEPTH-1:0][7:0]          prog;
    logic [STACK_DEPTH-1:0][7:0]         stk;
    logic [DATA_DEPTH-1:0][7:0]          dat;
  } slc_core_t;

endpackage

//--- slc_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module slc_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta_r <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule
`default_nettype wire

//--- slc_core.sv
// Purpose: byte-coded stack machine with serial host access port
// Assumes: one 10 MHz clock; all control pins asynchronous to it
// Notes:   host pins pass a two-stage synchroniser before use
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - 32 program, 32 stack, 8 data bytes, port
// - reset fills program 0xff, rest zero
// - four host registers at select 0..3
// - write strobe copies shifter into selected register
// - capture strobe loads shifter, msb shifts out
// - serial input shifts in msb first
// - opcode register executes once, pc kept unless jump or loop
// - stack top push on write, peek on read
// - data ram 0x00-0x07, io 0x20-0x5f
// - 0x36 reads pins, write toggles outputs
// - 0x37 direction mask, one means output
// - 0x38 sets output levels
// - run starts fetching at program counter
// - opcode 255 halts execution
// - unknown bytes pushed; pc advances by one
module slc_core
  import slc_pkg::*;
#(
  parameter int DELAY_CYCLES_P = DELAY_CYCLES
) (
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic       run_i,
  input  wire logic       step_i,
  input  wire logic       load_i,
  input  wire logic       dump_i,
  input  wire logic       shift_in_i,
  input  wire logic [1:0] reg_sel_i,
  input  wire logic [7:0] gpio_in_i,
  output logic      [7:0] gpio_out_o,
  output logic      [7:0] gpio_oe_o,
  output logic            sleep_o,
  output logic            stop_o,
  output logic            wait_delay_o,
  output logic            shift_out_o
);

  // ==========================================================
  // input synchronisers
  localparam logic [DELAY_CNT_W-1:0] DLY_LAST = DELAY_CNT_W'(DELAY_CYCLES_P - 1);

  logic [15:0] pins_s;
  logic        s_run;
  logic        s_step;
  logic        s_load;
  logic        s_dump;
  logic        s_sin;
  logic [1:0]  s_sel;
  logic [7:0]  s_gpio;

  slc_sync #(
    .W (16)
  ) u_sync (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .d_i       ({run_i, step_i, load_i, dump_i, shift_in_i, reg_sel_i, gpio_in_i, 1'b0}),
    .q_o       (pins_s)
  );

  assign s_run  = pins_s[15];
  assign s_step = pins_s[14];
  assign s_load = pins_s[13];
  assign s_dump = pins_s[12];
  assign s_sin  = pins_s[11];
  assign s_sel  = pins_s[10:9];
  assign s_gpio = pins_s[8:1];

  // ==========================================================
  // state registers
  slc_core_t st_r;
  slc_core_t st_nxt;

  // ==========================================================
  // data space read decode
  function automatic logic [7:0] data_rd(input slc_core_t s, input logic [7:0] a,
                                         input logic [7:0] pins);
    logic [7:0] v;
    v = 8'h00;
    if (a <= DADDR_RAM_LAST)
    begin
      v = s.dat[a[2:0]];
    end
    else if (a == DADDR_PIN_TOGGLE)
    begin
      v = pins;
    end
    else if (a == DADDR_DIRECTION)
    begin
      v = s.ddr;
    end
    else if (a == DADDR_OUTPUT_LEVEL)
    begin
      v = s.port;
    end
    return v;
  endfunction

  // ==========================================================
  // next state
  logic [7:0] rd_val;
  logic [7:0] op;
  logic       go;
  logic       cpu;
  logic       hold_pc;
  logic [4:0] i0;
  logic [4:0] i1;
  logic [4:0] i2;
  logic [7:0] ta;
  logic [7:0] tb;
  logic       run_edge;
  logic       step_edge;
  logic       load_edge;

  always_comb
  begin
    st_nxt    = st_r;
    op        = 8'h00;
    go        = 1'b0;
    cpu       = 1'b0;
    hold_pc   = 1'b0;
    i0        = st_r.sp[4:0];
    i1        = i0 - 5'h01;
    i2        = i0 - 5'h02;
    ta        = st_r.stk[i1];
    tb        = st_r.stk[i2];
    run_edge  = s_run & ~st_r.run_q;
    step_edge = s_step & ~st_r.step_q;
    load_edge = s_load & ~st_r.load_q;
    st_nxt.run_q  = s_run;
    st_nxt.step_q = s_step;
    st_nxt.load_q = s_load;

    if (s_sel == HREG_PROGRAM_COUNTER)
    begin
      rd_val = st_r.pc;
    end
    else if (s_sel == HREG_STACK_POINTER)
    begin
      rd_val = st_r.sp;
    end
    else if (s_sel == HREG_STACK_TOP_ACCESS)
    begin
      rd_val = ta;
    end
    else
    begin
      rd_val = 8'h00;
    end

    if (s_dump)
    begin
      st_nxt.sr = rd_val;
    end
    else if (!s_load)
    begin
      st_nxt.sr = {st_r.sr[6:0], s_sin};
    end

    // host write takes shifter, core stalls
    if (s_load)
    begin
      if (s_sel == HREG_PROGRAM_COUNTER)
      begin
        st_nxt.pc = st_r.sr;
      end
      else if (s_sel == HREG_STACK_POINTER)
      begin
        st_nxt.sp = st_r.sr;
      end
      else if (s_sel == HREG_IMMEDIATE_OPCODE)
      begin
        op = st_r.sr;
        go = load_edge;
      end
      else if (load_edge)
      begin
        st_nxt.stk[i0] = st_r.sr;
        st_nxt.sp      = st_r.sp + 8'h01;
      end
    end
    else
    begin
      case (st_r.state)
        ST_HALT:
        begin
          if (run_edge)
          begin
            st_nxt.state  = ST_RUN;
            st_nxt.single = 1'b0;
          end
          else if (step_edge)
          begin
            st_nxt.state  = ST_RUN;
            st_nxt.single = 1'b1;
          end
        end
        ST_RUN:
        begin
          op  = st_r.prog[st_r.pc[4:0]];
          go  = 1'b1;
          cpu = 1'b1;
        end
        ST_DELAY:
        begin
          if (st_r.ms == 8'h00)
          begin
            st_nxt.state = st_r.single ? ST_HALT : ST_RUN;
          end
          else if (st_r.cyc == DLY_LAST)
          begin
            st_nxt.cyc = '0;
            st_nxt.ms  = st_r.ms - 8'h01;
          end
          else
          begin
            st_nxt.cyc = st_r.cyc + DELAY_CNT_W'(1);
          end
        end
        ST_SLEEP:
        begin
          // wake source is run or step, no timer here
          if (run_edge || step_edge)
          begin
            st_nxt.state = st_r.single ? ST_HALT : ST_RUN;
          end
        end
        default:
        begin
          st_nxt.state = ST_HALT;
        end
      endcase
    end

    if (go)
    begin
      case (op)
        OP_DELAY:
        begin
          st_nxt.sp = st_r.sp - 8'h01;
          if (cpu)
          begin
            st_nxt.state = ST_DELAY;
            st_nxt.ms    = ta;
            st_nxt.cyc   = '0;
          end
        end
        OP_SHR:
        begin
          st_nxt.stk[i1] = {1'b0, ta[7:1]};
        end
        OP_SHL:
        begin
          st_nxt.stk[i1] = {ta[6:0], 1'b0};
        end
        OP_JUMP:
        begin
          st_nxt.pc = ta;
          st_nxt.sp = st_r.sp - 8'h01;
          hold_pc   = 1'b1;
        end
        OP_LOOP:
        begin
          if (tb != 8'h00)
          begin
            st_nxt.stk[i2] = tb - 8'h01;
            st_nxt.pc      = ta;
            st_nxt.sp      = st_r.sp - 8'h01;
            hold_pc        = 1'b1;
          end
          else
          begin
            st_nxt.sp = st_r.sp - 8'h02;
          end
        end
        OP_AND:
        begin
          st_nxt.stk[i2] = tb & ta;
          st_nxt.sp      = st_r.sp - 8'h01;
        end
        OP_OR:
        begin
          st_nxt.stk[i2] = tb | ta;
          st_nxt.sp      = st_r.sp - 8'h01;
        end
        OP_XOR:
        begin
          st_nxt.stk[i2] = tb ^ ta;
          st_nxt.sp      = st_r.sp - 8'h01;
        end
        OP_ADD:
        begin
          st_nxt.stk[i2] = tb + ta;
          st_nxt.sp      = st_r.sp - 8'h01;
        end
        OP_SUB:
        begin
          st_nxt.stk[i2] = tb - ta;
          st_nxt.sp      = st_r.sp - 8'h01;
        end
        OP_DUP:
        begin
          st_nxt.stk[i0] = ta;
          st_nxt.sp      = st_r.sp + 8'h01;
        end
        OP_PREAD:
        begin
          st_nxt.stk[i1] = st_r.prog[ta[4:0]];
        end
        OP_PWRITE:
        begin
          st_nxt.prog[ta[4:0]] = tb;
          st_nxt.sp            = st_r.sp - 8'h02;
        end
        OP_DREAD:
        begin
          st_nxt.stk[i1] = data_rd(st_r, ta, s_gpio);
        end
        OP_DWRITE:
        begin
          st_nxt.sp = st_r.sp - 8'h02;
          if (ta <= DADDR_RAM_LAST)
          begin
            st_nxt.dat[ta[2:0]] = tb;
          end
          else if (ta == DADDR_PIN_TOGGLE)
          begin
            st_nxt.port = st_r.port ^ tb;
          end
          else if (ta == DADDR_DIRECTION)
          begin
            st_nxt.ddr = tb;
          end
          else if (ta == DADDR_OUTPUT_LEVEL)
          begin
            st_nxt.port = tb;
          end
        end
        OP_ROT:
        begin
          st_nxt.stk[i0] = ta;
          st_nxt.stk[i1] = tb;
          st_nxt.stk[i2] = ta;
        end
        OP_SLEEP:
        begin
          if (cpu)
          begin
            st_nxt.state = ST_SLEEP;
          end
        end
        // halt keeps pc on the halt byte
        OP_HALT:
        begin
          hold_pc = 1'b1;
          if (cpu)
          begin
            st_nxt.state = ST_HALT;
          end
        end
        default:
        begin
          st_nxt.stk[i0] = op;
          st_nxt.sp      = st_r.sp + 8'h01;
        end
      endcase

      if (cpu && !hold_pc)
      begin
        st_nxt.pc = st_r.pc + 8'h01;
      end
      if (cpu && st_r.single && st_nxt.state == ST_RUN)
      begin
        st_nxt.state = ST_HALT;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_r        <= '0;
      st_r.state  <= ST_HALT;
      st_r.pc     <= PC_RESET;
      st_r.sp     <= SP_RESET;
      st_r.prog   <= {PROG_DEPTH{PROG_RESET}};
      st_r.stk    <= {STACK_DEPTH{STACK_RESET}};
      st_r.dat    <= {DATA_DEPTH{DATA_RESET}};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  // port pins driven from direction and level
  assign gpio_out_o   = st_r.port;
  assign gpio_oe_o    = st_r.ddr;
  assign stop_o       = (st_r.state == ST_HALT);
  assign sleep_o      = (st_r.state == ST_SLEEP);
  assign wait_delay_o = (st_r.state == ST_DELAY);
  // msb of shifter on serial output
  assign shift_out_o  = st_r.sr[7];

endmodule
`default_nettype wire

//--- slc_host.sv
// Purpose: host model for the serial access pins
// Assumes: pins change just after a rising edge
// Notes:   bytes go msb first, one bit a clock
`timescale 1ns/1ps
`default_nettype none
module slc_host
  import slc_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       shift_out_i,
  output logic            run_o,
  output logic            step_o,
  output logic            load_o,
  output logic            dump_o,
  output logic            shift_in_o,
  output logic      [1:0] reg_sel_o
);
  initial
  begin
    {run_o, step_o, load_o, dump_o, shift_in_o, reg_sel_o} = 7'h00;
  end
  // ====================
  // register access
  // shift, then strobe
  task automatic wr(input logic [1:0] sel, input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge clock_i);
      shift_in_o <= v[i];
    end
    @(posedge clock_i);
    reg_sel_o <= sel;
    load_o <= 1'b1;
    @(posedge clock_i);
    load_o <= 1'b0;
    // gap so the synced strobe falls first
    repeat (4) @(posedge clock_i);
  endtask
  // two clocks, then a bit a clock
  task automatic rd(input logic [1:0] sel, output logic [7:0] v);
    @(posedge clock_i);
    reg_sel_o <= sel;
    dump_o <= 1'b1;
    @(posedge clock_i);
    dump_o <= 1'b0;
    repeat (2) @(posedge clock_i);
    for (int i = 7; i >= 0; i--)
    begin
      @(negedge clock_i);
      v[i] = shift_out_i;
      @(posedge clock_i);
    end
  endtask
  task automatic cmd2(input logic [7:0] d, input logic [7:0] a, input logic [7:0] op);
    wr(HREG_STACK_TOP_ACCESS, d);
    wr(HREG_STACK_TOP_ACCESS, a);
    wr(HREG_IMMEDIATE_OPCODE, op);
  endtask
  task automatic pulse(input logic is_step);
    @(posedge clock_i);
    run_o <= !is_step;
    step_o <= is_step;
    @(posedge clock_i);
    run_o <= 1'b0;
    step_o <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask
endmodule
`default_nettype wire

//--- slc_core_properties.sv
// Purpose: port checks for the stack language core
// Assumes: host pins act two edges late
// Notes:   quiet_r counts edges with all strobes low
`timescale 1ns/1ps
`default_nettype none
module slc_core_properties
  import slc_pkg::*;
#(
  parameter int DELAY_CYCLES_P = DELAY_CYCLES
) (
  input wire logic       clock_i,
  input wire logic       reset_n_i,
  input wire logic       run_i,
  input wire logic       step_i,
  input wire logic       load_i,
  input wire logic       dump_i,
  input wire logic       shift_in_i,
  input wire logic [1:0] reg_sel_i,
  input wire logic [7:0] gpio_in_i,
  input wire logic [7:0] gpio_out_o,
  input wire logic [7:0] gpio_oe_o,
  input wire logic       sleep_o,
  input wire logic       stop_o,
  input wire logic       wait_delay_o,
  input wire logic       shift_out_o
);
  logic [3:0]  quiet_r;
  logic [31:0] dly_r;
  // ====================
  // helper counters
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      quiet_r <= 4'h0;
      dly_r <= 32'h0;
    end
    else
    begin
      quiet_r <= (run_i | step_i | load_i | dump_i) ? 4'h0 : quiet_r + 4'(quiet_r != 4'hf);
      dly_r <= (wait_delay_o & ~load_i) ? dly_r + 32'h1 : 32'h0;
    end
  end
  // ====================
  // assertions
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  a_reset_outputs_clean: assert property (
    $rose(reset_n_i) |-> stop_o && !sleep_o && !wait_delay_o && !shift_out_o
      && gpio_oe_o == 8'h00 && gpio_out_o == 8'h00)
    else $error("outputs wrong after reset");
  a_state_flags_exclusive: assert property ($onehot0({stop_o, sleep_o, wait_delay_o}))
    else $error("more than one state flag high");
  a_shift_through: assert property (quiet_r >= 4'ha |-> shift_out_o == $past(shift_in_i, 10))
    else $error("serial bit did not pass through shifter");
  a_opcode_reads_zero: assert property (
    dump_i && !load_i && reg_sel_i == HREG_IMMEDIATE_OPCODE |-> ##3 !shift_out_o)
    else $error("opcode register read not zero");
  a_halted_pins_hold: assert property (
    stop_o && $past(stop_o) && quiet_r >= 4'h4 |-> $stable(gpio_out_o) && $stable(gpio_oe_o))
    else $error("port changed while halted and idle");
  a_sleep_holds: assert property (sleep_o && quiet_r >= 4'h3 |=> sleep_o)
    else $error("sleep left without run or step");
  a_run_needs_pin: assert property ($fell(stop_o) |-> quiet_r < 4'h6)
    else $error("halt left without run or step");
  a_delay_bounded: assert property (dly_r <= 32'(255 * DELAY_CYCLES_P + 2))
    else $error("timed delay too long");
endmodule
bind slc_core slc_core_properties #(.DELAY_CYCLES_P(DELAY_CYCLES_P)) slc_core_properties_inst (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .run_i(run_i), .step_i(step_i),
  .load_i(load_i), .dump_i(dump_i), .shift_in_i(shift_in_i), .reg_sel_i(reg_sel_i),
  .gpio_in_i(gpio_in_i), .gpio_out_o(gpio_out_o), .gpio_oe_o(gpio_oe_o),
  .sleep_o(sleep_o), .stop_o(stop_o), .wait_delay_o(wait_delay_o),
  .shift_out_o(shift_out_o)
);
`default_nettype wire

//--- tb_slc_core.sv
// Purpose: self-checking bench for the stack core
// Assumes: delay unit cut to 4 cycles
// Notes:   host pins come from the host model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      $display("unexpected %s expected %h seen %h", nm, e, g); \
      fails++; \
    end \
  end
module tb_slc_core
  import slc_pkg::*;
;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] top;
    logic [7:0] sp;
  } slc_row_t;
  logic       clock_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       run, step, load, dump, sin, sout, sleep, stop, waitd;
  logic [1:0] sel;
  logic [7:0] gin = 8'h3c;
  logic [7:0] gout, goe, rv;
  int         fails = 0;
  int         checks_done = 0;
  int         cyc = 0;
  logic [7:0] prog [6] = '{8'h12, 8'h34, OP_ADD, 8'h02, OP_DELAY, OP_SLEEP};
  // operands 0x5c then 0x27; 0x41 is no opcode
  slc_row_t   rows [10] = '{'{OP_ADD, 8'h83, 8'h01}, '{OP_SUB, 8'h35, 8'h01},
    '{OP_AND, 8'h04, 8'h01}, '{OP_OR, 8'h7f, 8'h01}, '{OP_XOR, 8'h7b, 8'h01},
    '{OP_SHL, 8'h4e, 8'h02}, '{OP_SHR, 8'h13, 8'h02}, '{OP_DUP, 8'h27, 8'h03},
    '{OP_ROT, 8'h5c, 8'h02}, '{8'h41, 8'h41, 8'h03}};
  always #50 clock_i = ~clock_i;
  slc_core #(.DELAY_CYCLES_P(4)) slc_core_inst (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .run_i(run), .step_i(step),
    .load_i(load), .dump_i(dump), .shift_in_i(sin), .reg_sel_i(sel),
    .gpio_in_i(gin), .gpio_out_o(gout), .gpio_oe_o(goe), .sleep_o(sleep),
    .stop_o(stop), .wait_delay_o(waitd), .shift_out_o(sout)
  );
  slc_host slc_host_inst (
    .clock_i(clock_i), .shift_out_i(sout), .run_o(run), .step_o(step), .load_o(load),
    .dump_o(dump), .shift_in_o(sin), .reg_sel_o(sel)
  );
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic endt(input string nm);
    $display("test %s done, mismatches %0d", nm, fails);
  endtask
  task automatic rdreg(input logic [1:0] s);
    slc_host_inst.rd(s, rv);
  endtask
  task automatic peek(input logic [7:0] a, input logic [7:0] op);
    slc_host_inst.wr(HREG_STACK_TOP_ACCESS, a);
    slc_host_inst.wr(HREG_IMMEDIATE_OPCODE, op);
    rdreg(HREG_STACK_TOP_ACCESS);
  endtask
  // ====================
  // hang guard
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      summarize();
    end
  end
  // ====================
  // main sequence
  initial
  begin
    repeat (8) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    `CHK("stop", 1'b1, stop)
    `CHK("oe", 8'h00, goe)
    rdreg(HREG_PROGRAM_COUNTER);
    `CHK("pc", 8'h00, rv)
    rdreg(HREG_STACK_POINTER);
    `CHK("sp", 8'h00, rv)
    rdreg(HREG_IMMEDIATE_OPCODE);
    `CHK("opcode read", 8'h00, rv)
    peek(8'h05, OP_PREAD);
    `CHK("prog", PROG_RESET, rv)
    peek(8'h03, OP_DREAD);
    `CHK("data", DATA_RESET, rv)
    endt("reset");
    foreach (rows[i])
    begin
      slc_host_inst.wr(HREG_STACK_POINTER, 8'h00);
      slc_host_inst.cmd2(8'h5c, 8'h27, rows[i].op);
      rdreg(HREG_STACK_TOP_ACCESS);
      `CHK("top", rows[i].top, rv)
      rdreg(HREG_STACK_POINTER);
      `CHK("sp", rows[i].sp, rv)
      rdreg(HREG_PROGRAM_COUNTER);
      `CHK("pc", 8'h00, rv)
    end
    endt("opcodes");
    slc_host_inst.cmd2(8'h0f, DADDR_DIRECTION, OP_DWRITE);
    `CHK("oe", 8'h0f, goe)
    slc_host_inst.cmd2(8'ha5, DADDR_OUTPUT_LEVEL, OP_DWRITE);
    `CHK("out", 8'ha5, gout)
    slc_host_inst.cmd2(8'h0c, DADDR_PIN_TOGGLE, OP_DWRITE);
    `CHK("toggled", 8'ha9, gout)
    peek(DADDR_PIN_TOGGLE, OP_DREAD);
    `CHK("pins", 8'h3c, rv)
    gin <= 8'hc5;
    peek(DADDR_PIN_TOGGLE, OP_DREAD);
    `CHK("pins moved", 8'hc5, rv)
    slc_host_inst.cmd2(8'h99, DADDR_RAM_LAST, OP_DWRITE);
    peek(DADDR_RAM_LAST, OP_DREAD);
    `CHK("ram", 8'h99, rv)
    slc_host_inst.cmd2(8'h55, 8'h08, OP_DWRITE);
    peek(8'h08, OP_DREAD);
    `CHK("unmapped", 8'h00, rv)
    endt("data space");
    for (int i = 0; i < 6; i++)
      slc_host_inst.cmd2(prog[i], (i < 3) ? 8'(i) : 8'(i + 13), OP_PWRITE);
    slc_host_inst.wr(HREG_PROGRAM_COUNTER, 8'h00);
    slc_host_inst.pulse(1'b0);
    for (int i = 0; i < 20 && stop; i++) @(posedge clock_i);
    `CHK("running", 1'b0, stop)
    for (int i = 0; i < 50 && !stop; i++) @(posedge clock_i);
    `CHK("halted", 1'b1, stop)
    rdreg(HREG_STACK_TOP_ACCESS);
    `CHK("sum", 8'h46, rv)
    rdreg(HREG_PROGRAM_COUNTER);
    `CHK("halt pc", 8'h03, rv)
    slc_host_inst.wr(HREG_PROGRAM_COUNTER, 8'h00);
    slc_host_inst.pulse(1'b1);
    rdreg(HREG_PROGRAM_COUNTER);
    `CHK("step pc", 8'h01, rv)
    rdreg(HREG_STACK_TOP_ACCESS);
    `CHK("literal", 8'h12, rv)
    slc_host_inst.wr(HREG_PROGRAM_COUNTER, 8'h10);
    slc_host_inst.pulse(1'b0);
    for (int i = 0; i < 30 && !waitd; i++) @(posedge clock_i);
    `CHK("delay", 1'b1, waitd)
    for (int i = 0; i < 40 && !sleep; i++) @(posedge clock_i);
    `CHK("sleep", 1'b1, sleep)
    slc_host_inst.pulse(1'b0);
    for (int i = 0; i < 20 && !stop; i++) @(posedge clock_i);
    `CHK("woken halt", 1'b1, stop)
    rdreg(HREG_PROGRAM_COUNTER);
    `CHK("sleep pc", 8'h13, rv)
    slc_host_inst.wr(HREG_STACK_TOP_ACCESS, 8'h0b);
    slc_host_inst.wr(HREG_IMMEDIATE_OPCODE, OP_JUMP);
    rdreg(HREG_PROGRAM_COUNTER);
    `CHK("jump pc", 8'h0b, rv)
    // count 1 is taken: decrement, jump, pop one
    slc_host_inst.cmd2(8'h01, 8'h05, OP_LOOP);
    rdreg(HREG_PROGRAM_COUNTER);
    `CHK("loop pc", 8'h05, rv)
    rdreg(HREG_STACK_TOP_ACCESS);
    `CHK("loop count", 8'h00, rv)
    // count 0 falls through: pop two, pc kept
    slc_host_inst.wr(HREG_STACK_TOP_ACCESS, 8'h09);
    slc_host_inst.wr(HREG_IMMEDIATE_OPCODE, OP_LOOP);
    rdreg(HREG_PROGRAM_COUNTER);
    `CHK("loop done pc", 8'h05, rv)
    endt("run");
    // ==========================================================
    // mid-run reset
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    `CHK("reset out", 8'h00, gout)
    `CHK("reset oe", 8'h00, goe)
    `CHK("reset stop", 1'b1, stop)
    rdreg(HREG_PROGRAM_COUNTER);
    `CHK("reset pc", PC_RESET, rv)
    peek(8'h10, OP_PREAD);
    `CHK("reset prog", PROG_RESET, rv)
    endt("mid-run reset");
    summarize();
  end
endmodule
`default_nettype wire
